/* File: rtl/nvd_pkg.sv */
// Shared constants and types for the non-volatile data page controller
package nvd_pkg;

    // Array geometry
    localparam int unsigned PAGES      = 8;
    localparam int unsigned PAGE_BYTES = 16;
    localparam int unsigned PAGE_W     = 3;
    localparam int unsigned OFFS_W     = 4;
    localparam int unsigned LOC_W      = PAGE_W + OFFS_W;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONTROL    = 8'hCE;
    localparam logic [7:0] IDX_WRITE_BYTE = 8'hCF;
    localparam logic [7:0] IDX_ADDR_HIGH  = 8'hE0;
    localparam logic [7:0] IDX_ADDR_LOW   = 8'hE1;
    localparam logic [7:0] IDX_READ_BYTE  = 8'hE2;

    // Control fields
    localparam int unsigned ERASE_BIT = 7;
    localparam int unsigned WRITE_BIT = 6;

    // Reset and fill values
    localparam logic [7:0] WRITE_BYTE_RESET = 8'h00;
    localparam logic [7:0] ADDR_RESET       = 8'h00;
    localparam logic [7:0] ERASED_BYTE      = 8'hFF;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing at a 50 ns clock; least times round up
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned ERASE_TIME_NS = 5000;
    localparam int unsigned WRITE_TIME_NS = 2000;
    localparam int unsigned CNT_W         = 16;
    localparam int unsigned ERASE_CYCLES  =
        (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WRITE_CYCLES  =
        (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        OP_IDLE  = 2'b00,
        OP_ERASE = 2'b01,
        OP_WRITE = 2'b10
    } nvd_op_kind_t;

    typedef enum logic [1:0] {
        WS_IDLE = 2'b00,
        WS_RUN  = 2'b01,
        WS_RESP = 2'b10
    } nvd_wstate_t;

    typedef struct packed {
        nvd_op_kind_t        kind;
        logic [PAGE_W-1:0]   page;
        logic [OFFS_W-1:0]   offset;
        logic [7:0]          data;
    } nvd_op_t;

endpackage

/* File: rtl/nvd_timer.sv */
// Down counter that times one erase or write operation
`timescale 1ns/1ps
module nvd_timer #(
    parameter int unsigned W = nvd_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Start with a cycle count
    input  wire logic         start,
    input  wire logic [W-1:0] cycles,
    // One-cycle pulse at the end
    output logic              done
);

    logic [W-1:0] count_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= '0;
        end else if (start) begin
            count_q <= cycles;
        end else if (count_q != '0) begin
            count_q <= count_q - W'(1);
        end
    end

    // Pulse in the cycle the count reaches zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done <= 1'b0;
        end else begin
            done <= !start && (count_q == W'(1));
        end
    end

endmodule

/* File: rtl/nvd_store.sv */
// Byte array of the non-volatile data memory, held in flip-flops
`timescale 1ns/1ps
module nvd_store #(
    parameter int unsigned PAGES      = nvd_pkg::PAGES,
    parameter int unsigned PAGE_BYTES = nvd_pkg::PAGE_BYTES
) (
    // Clock
    input  wire logic                          clk,
    // Operation applied for one cycle
    input  wire logic                          apply,
    input  wire nvd_pkg::nvd_op_t              op,
    // Read port, combinational
    input  wire logic [nvd_pkg::LOC_W-1:0]     rd_loc,
    output logic [7:0]                         rd_data
);

    // No reset: contents persist like the real array
    logic [7:0] mem_q [PAGES*PAGE_BYTES];

    always_ff @(posedge clk) begin
        if (apply && op.kind == nvd_pkg::OP_ERASE) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                mem_q[{op.page, nvd_pkg::OFFS_W'(i)}] <= nvd_pkg::ERASED_BYTE;
            end
        end else if (apply && op.kind == nvd_pkg::OP_WRITE) begin
            mem_q[{op.page, op.offset}] <= op.data;
        end
    end

    assign rd_data = mem_q[rd_loc];

endmodule

/* File: rtl/nvd_top.sv */
// What this block does
// - Memory holds eight erasable pages of sixteen bytes each.
// - Page is chosen by bits 6 to 4 of the low address register before erase; the high register is not used.
// - Setting control bit 7 starts erasing the selected page.
// - Erase stalls the issuing write until done, then execution continues.
// - Setting control bit 6 with bit 7 clear programs the data byte and stalls the writer.
// - Stall is released once the byte write has finished.
// - Data enters through the write byte register; readback goes another path.
// - Zero command bits start nothing; bits 5 to 0 are reserved.
// - Write byte register resets to zero.
`timescale 1ns/1ps
module nvd_top #(
    parameter int unsigned ADDR_W       = 12,
    parameter int unsigned ERASE_CYCLES = nvd_pkg::ERASE_CYCLES,
    parameter int unsigned WRITE_CYCLES = nvd_pkg::WRITE_CYCLES
) (
    // Clock and reset
    input  wire logic              REF_CLK,
    input  wire logic              RST,
    // Write address channel
    input  wire logic [ADDR_W-1:0] AWADDR,
    input  wire logic [2:0]        AWPROT,
    input  wire logic              AWVALID,
    output logic                   AWREADY,
    // Write data channel
    input  wire logic [31:0]       WDATA,
    input  wire logic [3:0]        WSTRB,
    input  wire logic              WVALID,
    output logic                   WREADY,
    // Write response channel
    output logic [1:0]             BRESP,
    output logic                   BVALID,
    input  wire logic              BREADY,
    // Read address channel
    input  wire logic [ADDR_W-1:0] ARADDR,
    input  wire logic [2:0]        ARPROT,
    input  wire logic              ARVALID,
    output logic                   ARREADY,
    // Read data channel
    output logic [31:0]            RDATA,
    output logic [1:0]             RRESP,
    output logic                   RVALID,
    input  wire logic              RREADY,
    // Core stall while an operation runs
    output logic                   CPU_STALL
);

    localparam int unsigned CW = nvd_pkg::CNT_W;

    // Captured write request
    logic                  aw_held_q;
    logic [ADDR_W-1:0]     aw_addr_q;
    logic                  w_held_q;
    logic [7:0]            w_byte_q;
    logic                  w_lane0_q;

    // Write sequencing
    nvd_pkg::nvd_wstate_t  wstate_q;
    logic                  awready_q;
    logic                  wready_q;
    logic                  bvalid_q;
    logic [1:0]            bresp_q;

    // Registers
    logic                  erase_cmd_q;
    logic                  write_cmd_q;
    logic [7:0]            write_byte_q;
    logic [7:0]            addr_high_q;
    logic [7:0]            addr_low_q;
    logic                  stall_q;

    // Read channel
    logic                  arready_q;
    logic                  rvalid_q;
    logic [31:0]           rdata_q;
    logic [1:0]            rresp_q;

    // Decoded write
    logic                  wr_go;
    logic                  wr_mapped;
    logic                  wr_ctrl;
    logic                  wr_data;
    logic                  wr_high;
    logic                  wr_low;
    logic                  start_erase;
    logic                  start_write;
    logic                  start_op;

    // Operation path
    nvd_pkg::nvd_op_t      op_q;
    logic                  op_start;
    logic [CW-1:0]         op_cycles;
    logic                  op_done;
    logic [7:0]            store_rd;

    // True when an address is the aligned word address of an index
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a == ADDR_W'({idx, 2'b00}));
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = hit(a, nvd_pkg::IDX_CONTROL) || hit(a, nvd_pkg::IDX_WRITE_BYTE) ||
                 hit(a, nvd_pkg::IDX_ADDR_HIGH) || hit(a, nvd_pkg::IDX_ADDR_LOW) ||
                 hit(a, nvd_pkg::IDX_READ_BYTE);
    endfunction

    // Write decode once address and data are both held
    always_comb begin
        wr_go       = aw_held_q && w_held_q && (wstate_q == nvd_pkg::WS_IDLE);
        wr_mapped   = mapped(aw_addr_q);
        wr_ctrl     = wr_go && w_lane0_q && hit(aw_addr_q, nvd_pkg::IDX_CONTROL);
        wr_data     = wr_go && w_lane0_q && hit(aw_addr_q, nvd_pkg::IDX_WRITE_BYTE);
        wr_high     = wr_go && w_lane0_q && hit(aw_addr_q, nvd_pkg::IDX_ADDR_HIGH);
        wr_low      = wr_go && w_lane0_q && hit(aw_addr_q, nvd_pkg::IDX_ADDR_LOW);
        // Erase wins if both command bits are written together
        start_erase = wr_ctrl && w_byte_q[nvd_pkg::ERASE_BIT];
        start_write = wr_ctrl && !w_byte_q[nvd_pkg::ERASE_BIT]
                      && w_byte_q[nvd_pkg::WRITE_BIT];
        // Zero command bits and bits 5..0 have no effect
        start_op    = start_erase || start_write;
    end

    // Address channel capture
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
            awready_q <= 1'b1;
        end else if (AWVALID && awready_q) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= AWADDR;
            awready_q <= 1'b0;
        end else if (bvalid_q && BREADY) begin
            aw_held_q <= 1'b0;
            awready_q <= 1'b1;
        end
    end

    // Data channel capture; only byte lane 0 carries a register
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            w_held_q  <= 1'b0;
            w_byte_q  <= 8'h00;
            w_lane0_q <= 1'b0;
            wready_q  <= 1'b1;
        end else if (WVALID && wready_q) begin
            w_held_q  <= 1'b1;
            w_byte_q  <= WDATA[7:0];
            w_lane0_q <= WSTRB[0];
            wready_q  <= 1'b0;
        end else if (bvalid_q && BREADY) begin
            w_held_q  <= 1'b0;
            wready_q  <= 1'b1;
        end
    end

    // Response is withheld while an operation runs; that is the core's halt
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            wstate_q <= nvd_pkg::WS_IDLE;
            bvalid_q <= 1'b0;
            bresp_q  <= nvd_pkg::RESP_OKAY;
        end else begin
            unique case (wstate_q)
                nvd_pkg::WS_IDLE: begin
                    if (wr_go && start_op) begin
                        wstate_q <= nvd_pkg::WS_RUN;
                    end else if (wr_go) begin
                        wstate_q <= nvd_pkg::WS_RESP;
                        bvalid_q <= 1'b1;
                        bresp_q  <= wr_mapped ? nvd_pkg::RESP_OKAY : nvd_pkg::RESP_SLVERR;
                    end
                end
                nvd_pkg::WS_RUN: begin
                    if (op_done) begin
                        wstate_q <= nvd_pkg::WS_RESP;
                        bvalid_q <= 1'b1;
                        bresp_q  <= nvd_pkg::RESP_OKAY;
                    end
                end
                nvd_pkg::WS_RESP: begin
                    if (BREADY) begin
                        wstate_q <= nvd_pkg::WS_IDLE;
                        bvalid_q <= 1'b0;
                    end
                end
                default: begin
                    wstate_q <= nvd_pkg::WS_IDLE;
                    bvalid_q <= 1'b0;
                end
            endcase
        end
    end

    // Command bits stay set for the whole operation
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            erase_cmd_q <= 1'b0;
            write_cmd_q <= 1'b0;
        end else if (start_op) begin
            erase_cmd_q <= start_erase;
            write_cmd_q <= start_write;
        end else if (op_done) begin
            erase_cmd_q <= 1'b0;
            write_cmd_q <= 1'b0;
        end
    end

    // Data byte for programming
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            write_byte_q <= nvd_pkg::WRITE_BYTE_RESET;
        end else if (wr_data) begin
            write_byte_q <= w_byte_q;
        end
    end

    // Location registers; a write during an operation cannot happen
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            addr_high_q <= nvd_pkg::ADDR_RESET;
            addr_low_q  <= nvd_pkg::ADDR_RESET;
        end else begin
            if (wr_high) begin
                addr_high_q <= w_byte_q;
            end
            if (wr_low) begin
                addr_low_q <= w_byte_q;
            end
        end
    end

    // Operation latched at start so later register writes cannot disturb it
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            op_q <= '{kind: nvd_pkg::OP_IDLE, page: '0, offset: '0, data: 8'h00};
        end else if (start_op) begin
            op_q.kind   <= start_erase ? nvd_pkg::OP_ERASE : nvd_pkg::OP_WRITE;
            op_q.page   <= addr_low_q[nvd_pkg::LOC_W-1:nvd_pkg::OFFS_W];
            op_q.offset <= addr_low_q[nvd_pkg::OFFS_W-1:0];
            op_q.data   <= write_byte_q;
        end else if (op_done) begin
            op_q.kind <= nvd_pkg::OP_IDLE;
        end
    end

    // Stall line follows the running operation
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            stall_q <= 1'b0;
        end else if (start_op) begin
            stall_q <= 1'b1;
        end else if (op_done) begin
            stall_q <= 1'b0;
        end
    end

    assign op_start  = start_op;
    assign op_cycles = start_erase ? CW'(ERASE_CYCLES) : CW'(WRITE_CYCLES);

    nvd_timer #(
        .W      (CW)
    ) u_timer (
        .clk    (REF_CLK),
        .rst    (RST),
        .start  (op_start),
        .cycles (op_cycles),
        .done   (op_done)
    );

    // Array is changed at completion, so an aborted op leaves it intact
    nvd_store #(
        .PAGES      (nvd_pkg::PAGES),
        .PAGE_BYTES (nvd_pkg::PAGE_BYTES)
    ) u_store (
        .clk        (REF_CLK),
        .apply      (op_done),
        .op         (op_q),
        .rd_loc     (addr_low_q[nvd_pkg::LOC_W-1:0]),
        .rd_data    (store_rd)
    );

    // Read channel; write byte register reads as zero
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= nvd_pkg::RESP_OKAY;
        end else if (ARVALID && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= mapped(ARADDR) ? nvd_pkg::RESP_OKAY : nvd_pkg::RESP_SLVERR;
            if (hit(ARADDR, nvd_pkg::IDX_CONTROL)) begin
                rdata_q <= {24'h000000, erase_cmd_q, write_cmd_q, 6'h00};
            end else if (hit(ARADDR, nvd_pkg::IDX_ADDR_HIGH)) begin
                rdata_q <= {24'h000000, addr_high_q};
            end else if (hit(ARADDR, nvd_pkg::IDX_ADDR_LOW)) begin
                rdata_q <= {24'h000000, addr_low_q};
            end else if (hit(ARADDR, nvd_pkg::IDX_READ_BYTE)) begin
                rdata_q <= {24'h000000, store_rd};
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end else if (rvalid_q && RREADY) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign AWREADY   = awready_q;
    assign WREADY    = wready_q;
    assign BVALID    = bvalid_q;
    assign BRESP     = bresp_q;
    assign ARREADY   = arready_q;
    assign RVALID    = rvalid_q;
    assign RDATA     = rdata_q;
    assign RRESP     = rresp_q;
    assign CPU_STALL = stall_q;

endmodule

/* File: dv/nvd_checker.sv */
// Port assertions for the data page controller
`timescale 1ns/1ps
module nvd_checker #(
    parameter int unsigned ERASE_CYCLES = nvd_pkg::ERASE_CYCLES,
    parameter int unsigned WRITE_CYCLES = nvd_pkg::WRITE_CYCLES
) (
    // Clock and reset
    input wire logic        REF_CLK,
    input wire logic        RST,
    // Write side
    input wire logic        AWREADY,
    input wire logic        WREADY,
    input wire logic [1:0]  BRESP,
    input wire logic        BVALID,
    input wire logic        BREADY,
    // Read side
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic        RVALID,
    input wire logic        RREADY,
    // Stall
    input wire logic        CPU_STALL
);
    logic [15:0] run_q;

    // Length of the current stall, read back when it ends
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            run_q <= 16'h0000;
        end else if (CPU_STALL) begin
            run_q <= run_q + 16'h0001;
        end else begin
            run_q <= 16'h0000;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    property p_stall_len;
        // Stall spans the timed cycles plus the cycle that ends it
        $fell(CPU_STALL) |-> (run_q == ERASE_CYCLES + 1 || run_q == WRITE_CYCLES + 1);
    endproperty
    a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
    property p_no_b_in_stall;
        CPU_STALL |-> !BVALID;
    endproperty
    a_no_b_in_stall: assert property (p_no_b_in_stall) else $error("answer during stall");
    property p_b_after_stall;
        $fell(CPU_STALL) |-> BVALID;
    endproperty
    a_b_after_stall: assert property (p_b_after_stall) else $error("no answer at end");
    property p_stall_from_write;
        $rose(CPU_STALL) |-> !AWREADY && !WREADY;
    endproperty
    a_stall_from_write: assert property (p_stall_from_write) else $error("stray stall");
    property p_b_hold;
        BVALID && !BREADY |=> BVALID && $stable(BRESP);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_one_write;
        BVALID |-> !AWREADY && !WREADY;
    endproperty
    a_one_write: assert property (p_one_write) else $error("write taken early");
    property p_r_lat;
        ARVALID && ARREADY |=> RVALID && !ARREADY;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_r_hold;
        RVALID && !RREADY |=> RVALID && $stable(RDATA);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_r_width;
        RVALID |-> RDATA[31:8] == 24'h000000;
    endproperty
    a_r_width: assert property (p_r_width) else $error("read data too wide");

    c_stall: cover property ($rose(CPU_STALL));
    c_slverr: cover property (BVALID && BRESP == nvd_pkg::RESP_SLVERR);
    c_slow_read: cover property (RVALID && !RREADY);
endmodule

bind nvd_top nvd_checker #(.ERASE_CYCLES(ERASE_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) u_chk (
    .REF_CLK(REF_CLK), .RST(RST), .AWREADY(AWREADY), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY), .CPU_STALL(CPU_STALL));

/* File: dv/nvd_cpu_model.sv */
// Bus master model of the core that issues register accesses
`timescale 1ns/1ps
module nvd_cpu_model (
    // Clock
    input  wire logic        clk,
    // Write channels
    output logic [11:0]      awaddr,
    output logic [2:0]       awprot,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    // Read channels
    output logic [11:0]      araddr,
    output logic [2:0]       arprot,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    // Cycles to wait before accepting an answer
    int lag = 0;

    initial begin
        {awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arprot, arvalid, rready} = '0;
    end

    // Released payload shows the inverse, never the last value
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        int n;
        logic ta, tw;
        ta = 1'b0; tw = 1'b0; n = 0; r = 2'h3;
        awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1;
        // Waits for the answer however long; only the bench watchdog ends a hang
        forever begin
            @(posedge clk);
            if (bvalid && bready) begin
                r = bresp; bready <= 1'b0; break;
            end
            if (awvalid && awready) begin awvalid <= 1'b0; awaddr <= ~a; ta = 1'b1; end
            if (wvalid && wready) begin wvalid <= 1'b0; wdata <= ~d; tw = 1'b1; end
            if (ta && tw) begin n++; if (n > lag) bready <= 1'b1; end
        end
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic t;
        t = 1'b0; n = 0; d = '1; r = 2'h3;
        araddr <= a; arvalid <= 1'b1;
        forever begin
            @(posedge clk);
            if (rvalid && rready) begin
                d = rdata; r = rresp; rready <= 1'b0; break;
            end
            if (arvalid && arready) begin arvalid <= 1'b0; araddr <= ~a; t = 1'b1; end
            if (t) begin n++; if (n > lag) rready <= 1'b1; end
        end
    endtask
endmodule

/* File: dv/nvd_top_tb.sv */
// Self-checking bench for the data page controller
`timescale 1ns/1ps
module nvd_top_tb;
    localparam int EC = 3;
    localparam int WC = 3;
    localparam logic [11:0] A_CTL = {2'b00, nvd_pkg::IDX_CONTROL, 2'b00};
    localparam logic [11:0] A_WB  = {2'b00, nvd_pkg::IDX_WRITE_BYTE, 2'b00};
    localparam logic [11:0] A_HIGH = {2'b00, nvd_pkg::IDX_ADDR_HIGH, 2'b00};
    localparam logic [11:0] A_LOW = {2'b00, nvd_pkg::IDX_ADDR_LOW, 2'b00};
    localparam logic [11:0] A_RD  = {2'b00, nvd_pkg::IDX_READ_BYTE, 2'b00};

    logic        REF_CLK, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    logic        ARVALID, ARREADY, RVALID, RREADY, CPU_STALL;
    logic [11:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA;
    logic [3:0]  WSTRB;
    logic [2:0]  AWPROT, ARPROT;
    logic [1:0]  BRESP, RRESP;
    int          errors = 0;
    int          checks_done = 0;
    int          stall_n = 0;

    nvd_top #(.ADDR_W(12), .ERASE_CYCLES(EC), .WRITE_CYCLES(WC)) dut (
        .REF_CLK(REF_CLK), .RST(RST), .AWADDR(AWADDR), .AWPROT(AWPROT), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARPROT(ARPROT),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY), .CPU_STALL(CPU_STALL));

    nvd_cpu_model cpu (
        .clk(REF_CLK), .awaddr(AWADDR), .awprot(AWPROT), .awvalid(AWVALID),
        .awready(AWREADY), .wdata(WDATA), .wstrb(WSTRB), .wvalid(WVALID), .wready(WREADY),
        .bresp(BRESP), .bvalid(BVALID), .bready(BREADY), .araddr(ARADDR), .arprot(ARPROT),
        .arvalid(ARVALID), .arready(ARREADY), .rdata(RDATA), .rresp(RRESP),
        .rvalid(RVALID), .rready(RREADY));

    initial begin
        REF_CLK = 1'b0;
        forever #25 REF_CLK = ~REF_CLK;
    end

    always @(posedge REF_CLK) begin
        if (CPU_STALL === 1'b1) stall_n <= stall_n + 1;
    end

    task automatic wrap_up;
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic put(input logic [11:0] a, input logic [7:0] v);
        logic [1:0] r;
        cpu.wr(a, {24'h000000, v}, 4'hF, r);
        cmp({30'h0, r}, {30'h0, nvd_pkg::RESP_OKAY});
    endtask

    task automatic get(input logic [11:0] a, input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        cpu.rd(a, d, r);
        cmp(d, {24'h000000, exp});
        cmp({30'h0, r}, {30'h0, nvd_pkg::RESP_OKAY});
    endtask

    task automatic chk_byte(input logic [7:0] loc, input logic [7:0] exp);
        put(A_LOW, loc);
        get(A_RD, exp);
    endtask

    // Command with stall length; control must read idle afterwards
    task automatic op(input logic [7:0] cmd, input int len);
        int s0;
        s0 = stall_n;
        put(A_CTL, cmd);
        // Stall spans the timed cycles plus the cycle that ends it
        cmp(stall_n - s0, (len == 0) ? 0 : len + 1);
        get(A_CTL, 8'h00);
    endtask

    task automatic t_reset;
        get(A_CTL, 8'h00);
        put(A_LOW, 8'h00);
        op(8'h80, EC);
        op(8'h40, WC);
        chk_byte(8'h00, nvd_pkg::WRITE_BYTE_RESET);
        chk_byte(8'h01, nvd_pkg::ERASED_BYTE);
    endtask

    task automatic t_erase;
        for (int p = 0; p < 8; p++) begin
            put(A_LOW, 8'(p * 16));
            op(8'h80, EC);
            chk_byte(8'(p * 16), nvd_pkg::ERASED_BYTE);
            chk_byte(8'(p * 16 + 15), nvd_pkg::ERASED_BYTE);
        end
    endtask

    task automatic t_write;
        put(A_WB, 8'hA5);
        put(A_HIGH, 8'h01);
        get(A_HIGH, 8'h01);
        put(A_LOW, 8'h2F);
        op(8'h40, WC);
        chk_byte(8'h2F, 8'hA5);
        chk_byte(8'h2E, nvd_pkg::ERASED_BYTE);
        chk_byte(8'h30, nvd_pkg::ERASED_BYTE);
        get(A_WB, 8'h00);
    endtask

    task automatic t_zero;
        put(A_WB, 8'h5A);
        put(A_LOW, 8'h2F);
        op(8'h3F, 0);
        chk_byte(8'h2F, 8'hA5);
        op(8'hC0, EC);
        chk_byte(8'h2F, nvd_pkg::ERASED_BYTE);
    endtask

    // Slow answers, unmapped place and a write with no byte lane
    task automatic t_refuse;
        logic [1:0]  r;
        logic [31:0] d;
        cpu.lag = 2;
        cpu.wr(12'h3F0, 32'h0000_00FF, 4'hF, r);
        cmp({30'h0, r}, {30'h0, nvd_pkg::RESP_SLVERR});
        cpu.rd(12'h3F0, d, r);
        cmp(d, 32'h0000_0000);
        cmp({30'h0, r}, {30'h0, nvd_pkg::RESP_SLVERR});
        cpu.wr(A_WB, 32'h0000_0077, 4'h0, r);
        cmp({30'h0, r}, {30'h0, nvd_pkg::RESP_OKAY});
        put(A_LOW, 8'h2F);
        op(8'h40, WC);
        chk_byte(8'h2F, 8'h5A);
        cpu.lag = 0;
    endtask

    initial begin
        RST = 1'b1;
        repeat (3) @(posedge REF_CLK);
        RST <= 1'b0;
        t_reset();
        t_erase();
        t_write();
        t_zero();
        t_refuse();
        wrap_up();
    end

    // Whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge REF_CLK);
        errors++;
        wrap_up();
    end
endmodule
